// File: verilog/hfa_top.sv
`timescale 1ns/10ps
module hfa_top #(
	parameter int TONE_LO_HALF = hfa_pkg::TONE_LO_HALF,
	parameter int TONE_HI_HALF = hfa_pkg::TONE_HI_HALF,
	parameter int TONE_PHASE_CYC = hfa_pkg::TONE_PHASE_CYC,
	parameter logic [7:0] ALARM_EN_A_INIT = hfa_pkg::ALARM_EN_A_RESET,
	parameter logic [7:0] ALARM_EN_B_INIT = hfa_pkg::ALARM_EN_B_RESET,
	parameter logic [7:0] ALARM_EXTRA_INIT = hfa_pkg::ALARM_EXTRA_RESET
) (
	// Clock and reset
	input wire logic clock_i,
	input wire logic srst_i,
	// Host byte I/O
	input wire hfa_pkg::hfa_io_req_s io_req_i,
	output logic [7:0] io_rdata_o,
	output logic io_rvalid_o,
	// Configuration bytes and bank selection
	input wire hfa_pkg::hfa_cfg_s cfg_i,
	input wire logic [3:0] bank_select_i,
	// Monitored events, one level per enable bit
	input wire logic [hfa_pkg::NUM_EVENTS-1:0] event_i,
	// System fan
	output logic system_fan_drive_o,
	output logic [5:0] fan_dc_level_o,
	output logic fan_dc_mode_o,
	// Alarm tone open-drain pin
	output logic alarm_tone_out_o,
	output logic alarm_tone_oe_o
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------

	// Match of a bank and index against the current selection
	function automatic logic reg_hit(input logic [3:0] bank_sel,
		input logic [6:0] idx, input logic [3:0] bank,
		input logic [6:0] want);
		reg_hit = (bank_sel == bank) && (idx == want);
	endfunction

	// ----------------------------------------------------------------
	// Port decode
	// ----------------------------------------------------------------
	wire [15:0] base_addr = {cfg_i.high, cfg_i.low};
	wire [15:0] index_port = base_addr + hfa_pkg::INDEX_PORT_OFS;
	wire [15:0] data_port = base_addr + hfa_pkg::DATA_PORT_OFS;
	wire index_sel = (io_req_i.addr == index_port);
	wire data_sel = (io_req_i.addr == data_port);
	wire index_wr = index_sel && io_req_i.wr;
	wire data_wr = data_sel && io_req_i.wr;
	wire any_rd = (index_sel || data_sel) && io_req_i.rd;

	// ----------------------------------------------------------------
	// Index pointer
	// ----------------------------------------------------------------
	logic [6:0] index_q;

	// Only the low seven bits are stored; bit 7 has no flop
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			index_q <= hfa_pkg::INDEX_RESET;
		end else if (index_wr) begin
			index_q <= io_req_i.wdata[6:0];
		end
	end

	// ----------------------------------------------------------------
	// Register select
	// ----------------------------------------------------------------
	// Bank 0 hits need bank 0 selected outside this block
	wire hit_freq = reg_hit(bank_select_i, index_q, hfa_pkg::BANK_FAN,
		hfa_pkg::IDX_FAN_FREQ);
	wire hit_level = reg_hit(bank_select_i, index_q, hfa_pkg::BANK_FAN,
		hfa_pkg::IDX_FAN_LEVEL);
	wire hit_cfg = reg_hit(bank_select_i, index_q, hfa_pkg::BANK_FAN,
		hfa_pkg::IDX_FAN_CFG);
	wire hit_en_a = reg_hit(bank_select_i, index_q, hfa_pkg::BANK_FAN,
		hfa_pkg::IDX_ALARM_EN_A);
	wire hit_en_b = reg_hit(bank_select_i, index_q, hfa_pkg::BANK_FAN,
		hfa_pkg::IDX_ALARM_EN_B);
	wire hit_extra = reg_hit(bank_select_i, index_q, hfa_pkg::BANK_EXTRA,
		hfa_pkg::IDX_ALARM_EXTRA);

	// ----------------------------------------------------------------
	// Indexed register file
	// ----------------------------------------------------------------
	logic [7:0] fan_freq_q;
	logic [7:0] fan_level_q;
	logic [7:0] fan_cfg_q;
	logic [7:0] alarm_en_a_q;
	logic [7:0] alarm_en_b_q;
	logic [7:0] alarm_extra_q;

	// Frequency byte written through the data window
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			fan_freq_q <= hfa_pkg::FAN_FREQ_RESET;
		end else if (data_wr && hit_freq) begin
			fan_freq_q <= io_req_i.wdata;
		end
	end

	// Output value byte; reset gives full drive
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			fan_level_q <= hfa_pkg::FAN_LEVEL_RESET;
		end else if (data_wr && hit_level) begin
			fan_level_q <= io_req_i.wdata;
		end
	end

	// Mode byte; the reserved top bits never store
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			fan_cfg_q <= hfa_pkg::FAN_CFG_RESET;
		end else if (data_wr && hit_cfg) begin
			fan_cfg_q <= io_req_i.wdata & hfa_pkg::FAN_CFG_MASK;
		end
	end

	// First byte of event enables
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			alarm_en_a_q <= ALARM_EN_A_INIT;
		end else if (data_wr && hit_en_a) begin
			alarm_en_a_q <= io_req_i.wdata;
		end
	end

	// Master enable on top of the second byte of event enables
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			alarm_en_b_q <= ALARM_EN_B_INIT;
		end else if (data_wr && hit_en_b) begin
			alarm_en_b_q <= io_req_i.wdata;
		end
	end

	// Extra enables and user alarm; unused bits stay zero
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			alarm_extra_q <= ALARM_EXTRA_INIT & hfa_pkg::EXTRA_MASK;
		end else if (data_wr && hit_extra) begin
			alarm_extra_q <= io_req_i.wdata & hfa_pkg::EXTRA_MASK;
		end
	end

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	// Unmapped indexes read zero; the value RAM lives elsewhere
	wire [7:0] window_data =
		hit_freq ? fan_freq_q :
		hit_level ? fan_level_q :
		hit_cfg ? fan_cfg_q :
		hit_en_a ? alarm_en_a_q :
		hit_en_b ? alarm_en_b_q :
		hit_extra ? alarm_extra_q : 8'h00;
	wire [7:0] read_mux = index_sel ? {1'b0, index_q} : window_data;
	logic [7:0] rdata_q;
	logic rvalid_q;

	// Read data registered; answer one cycle after the strobe
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			rdata_q <= 8'h00;
			rvalid_q <= 1'b0;
		end else begin
			rvalid_q <= any_rd;
			if (any_rd) begin
				rdata_q <= read_mux;
			end
		end
	end

	assign io_rdata_o = rdata_q;
	assign io_rvalid_o = rvalid_q;

	// ----------------------------------------------------------------
	// Fan clock source
	// ----------------------------------------------------------------
	wire pwm_mode = !fan_cfg_q[hfa_pkg::CFG_DC_BIT];
	wire src_slow = fan_freq_q[hfa_pkg::FREQ_SRC_BIT];
	wire [6:0] divider = fan_freq_q[6:0];
	// A zero divider is treated as one so the output never freezes
	wire [6:0] div_limit = (divider == 7'h00) ? 7'h01 : divider;
	wire [13:0] acc_inc = src_slow ? hfa_pkg::ACC_INC_SLOW :
		hfa_pkg::ACC_INC_FAST;
	logic [13:0] acc_q;
	wire [14:0] acc_sum = {1'b0, acc_q} + {1'b0, acc_inc};
	wire src_tick = (acc_sum >= {1'b0, hfa_pkg::ACC_MOD});
	wire [14:0] acc_wrap = acc_sum - {1'b0, hfa_pkg::ACC_MOD};
	wire [13:0] acc_d = src_tick ? acc_wrap[13:0] : acc_sum[13:0];

	// Fractional accumulator: 24 MHz ticks jitter by one clock
	always_ff @(posedge clock_i) begin
		if (srst_i || !pwm_mode) begin
			acc_q <= 14'h0000;
		end else begin
			acc_q <= acc_d;
		end
	end

	// ----------------------------------------------------------------
	// Prescaler and PWM counter
	// ----------------------------------------------------------------
	logic [6:0] pre_cnt_q;
	logic [7:0] pwm_cnt_q;
	wire pre_end = src_tick && (pre_cnt_q >= div_limit - 7'h01);

	// Divide the source by the divider, then step 256 slots
	always_ff @(posedge clock_i) begin
		if (srst_i || !pwm_mode) begin
			pre_cnt_q <= 7'h00;
			pwm_cnt_q <= 8'h00;
		end else if (src_tick) begin
			pre_cnt_q <= pre_end ? 7'h00 : pre_cnt_q + 7'h01;
			if (pre_end) begin
				pwm_cnt_q <= pwm_cnt_q + 8'h01;
			end
		end
	end

	// ----------------------------------------------------------------
	// Fan outputs
	// ----------------------------------------------------------------
	// FFh must be solid on, so it bypasses the compare
	wire duty_on = (fan_level_q == 8'hFF) || (pwm_cnt_q < fan_level_q);
	logic fan_drive_q;
	logic [5:0] dc_level_q;
	logic dc_mode_q;

	// Registered so the pin never glitches on a compare edge
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			fan_drive_q <= 1'b0;
		end else begin
			fan_drive_q <= pwm_mode && duty_on;
		end
	end

	// Level code follows the value byte in either mode
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			dc_level_q <= 6'h00;
		end else begin
			dc_level_q <= fan_level_q[7:2];
		end
	end

	// Mode flag starts in level mode, as the reset mode byte does
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			dc_mode_q <= 1'b1;
		end else begin
			dc_mode_q <= !pwm_mode;
		end
	end

	assign system_fan_drive_o = fan_drive_q;
	assign fan_dc_level_o = dc_level_q;
	assign fan_dc_mode_o = dc_mode_q;

	// ----------------------------------------------------------------
	// Alarm decision
	// ----------------------------------------------------------------
	wire [hfa_pkg::NUM_EVENTS-1:0] event_en =
		{alarm_extra_q[1:0], alarm_en_b_q[6:0], alarm_en_a_q};
	wire master_en = alarm_en_b_q[hfa_pkg::MASTER_EN_BIT];
	wire user_alarm = alarm_extra_q[hfa_pkg::USER_ALARM_BIT];
	wire any_event = (|(event_i & event_en)) || user_alarm;
	wire alarm_active = master_en && any_event;
	wire pin_is_alarm = !cfg_i.pin_function[hfa_pkg::PIN_SERIAL_BIT];

	// ----------------------------------------------------------------
	// Tone generator and pin
	// ----------------------------------------------------------------
	logic tone_wave;

	hfa_tone_gen #(
		.LO_HALF(TONE_LO_HALF),
		.HI_HALF(TONE_HI_HALF),
		.PHASE_CYC(TONE_PHASE_CYC)
	) u_tone (
		.clock_i(clock_i),
		.srst_i(srst_i),
		.active_i(alarm_active),
		.wave_o(tone_wave)
	);

	logic tone_oe_q;

	// Low phase pulls the pin; high phase releases it to the pull-up
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			tone_oe_q <= 1'b0;
		end else begin
			tone_oe_q <= pin_is_alarm && !tone_wave;
		end
	end

	// Open drain never drives a high level
	assign alarm_tone_out_o = 1'b0;
	assign alarm_tone_oe_o = tone_oe_q;

endmodule

// File: verilog/hfa_pkg.sv
// What this block does
// - Tone sounds only with master alarm enable set
// - Each event gated by its own enable bit
// - Open-drain tone pin rests low when idle
// - Alternate 600 Hz and 1.2 kHz, 0.5 s each
// - Base address from high and low config bytes
// - Index port at base+5, data at base+6
// - Seven-bit index pointer, bit 7 reads zero
// - Data port reads/writes the indexed register
// - Frequency bit 7 picks 24 MHz or 180 kHz
// - PWM rate is source over divider over 256
// - Frequency settings act only in PWM mode
// - Duty is value over 256, FFh full on
// - Mode bit 0: PWM or DC, DC after reset
// - Pin is alarm only when config bit 1 clear
// - Writing user alarm bit counts as an event
package hfa_pkg;

	// ----------------------------------------------------------------
	// Host port layout
	// ----------------------------------------------------------------
	localparam logic [15:0] INDEX_PORT_OFS = 16'h0005;
	localparam logic [15:0] DATA_PORT_OFS = 16'h0006;
	localparam logic [6:0] INDEX_RESET = 7'h00;

	// ----------------------------------------------------------------
	// Indexed registers
	// ----------------------------------------------------------------
	localparam logic [3:0] BANK_FAN = 4'h0;
	localparam logic [3:0] BANK_EXTRA = 4'h4;
	localparam logic [6:0] IDX_FAN_FREQ = 7'h00;
	localparam logic [6:0] IDX_FAN_LEVEL = 7'h01;
	localparam logic [6:0] IDX_FAN_CFG = 7'h04;
	localparam logic [6:0] IDX_ALARM_EN_A = 7'h56;
	localparam logic [6:0] IDX_ALARM_EN_B = 7'h57;
	localparam logic [6:0] IDX_ALARM_EXTRA = 7'h53;
	localparam logic [7:0] FAN_FREQ_RESET = 8'h04;
	localparam logic [7:0] FAN_LEVEL_RESET = 8'hFF;
	localparam logic [7:0] FAN_CFG_RESET = 8'h01;
	localparam logic [7:0] ALARM_EN_A_RESET = 8'h00;
	localparam logic [7:0] ALARM_EN_B_RESET = 8'h00;
	localparam logic [7:0] ALARM_EXTRA_RESET = 8'h00;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int FREQ_SRC_BIT = 7;
	localparam int CFG_DC_BIT = 0;
	localparam int MASTER_EN_BIT = 7;
	localparam int USER_ALARM_BIT = 5;
	localparam int PIN_SERIAL_BIT = 1;
	localparam int NUM_EVENTS = 17;
	localparam logic [7:0] FAN_CFG_MASK = 8'h3F;
	localparam logic [7:0] EXTRA_MASK = 8'h23;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ = 100_000_000;
	localparam int SRC_FAST_HZ = 24_000_000;
	localparam int SRC_SLOW_HZ = 180_000;
	// Source ticks come from a phase accumulator in units of 10 kHz
	localparam int ACC_UNIT_HZ = 10_000;
	localparam logic [13:0] ACC_MOD = 14'(CLK_HZ / ACC_UNIT_HZ);
	localparam logic [13:0] ACC_INC_FAST = 14'(SRC_FAST_HZ / ACC_UNIT_HZ);
	localparam logic [13:0] ACC_INC_SLOW = 14'(SRC_SLOW_HZ / ACC_UNIT_HZ);
	localparam int PWM_STEPS = 256;
	localparam int TONE_LO_HZ = 600;
	localparam int TONE_HI_HZ = 1200;
	localparam int TONE_PHASE_MS = 500;
	localparam int TONE_LO_HALF = CLK_HZ / (2 * TONE_LO_HZ);
	localparam int TONE_HI_HALF = CLK_HZ / (2 * TONE_HI_HZ);
	localparam int TONE_PHASE_CYC = CLK_HZ / 1000 * TONE_PHASE_MS;

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [15:0] addr;
		logic wr;
		logic rd;
		logic [7:0] wdata;
	} hfa_io_req_s;

	typedef struct packed {
		logic [7:0] high;
		logic [7:0] low;
		logic [7:0] pin_function;
	} hfa_cfg_s;

endpackage

// File: verilog/hfa_tone_gen.sv
`timescale 1ns/10ps
module hfa_tone_gen #(
	parameter int LO_HALF = hfa_pkg::TONE_LO_HALF,
	parameter int HI_HALF = hfa_pkg::TONE_HI_HALF,
	parameter int PHASE_CYC = hfa_pkg::TONE_PHASE_CYC
) (
	// Clock and reset
	input wire logic clock_i,
	input wire logic srst_i,
	// Control
	input wire logic active_i,
	// Tone level, 1 means released high
	output logic wave_o
);

	// ----------------------------------------------------------------
	// Counters
	// ----------------------------------------------------------------
	logic [31:0] phase_cnt_q;
	logic [31:0] half_cnt_q;
	logic use_hi_q;
	logic wave_q;
	wire [31:0] half_lim = use_hi_q ? 32'(HI_HALF) : 32'(LO_HALF);
	wire phase_end = (phase_cnt_q == 32'(PHASE_CYC - 1));
	wire half_end = (half_cnt_q >= half_lim - 32'h0000_0001);

	// Idle clears everything so a new alarm starts on the low tone
	always_ff @(posedge clock_i) begin
		if (srst_i || !active_i) begin
			phase_cnt_q <= 32'h0000_0000;
			half_cnt_q <= 32'h0000_0000;
			use_hi_q <= 1'b0;
			wave_q <= 1'b0;
		end else begin
			phase_cnt_q <= phase_end ? 32'h0000_0000 : phase_cnt_q + 1'b1;
			if (phase_end) begin
				use_hi_q <= !use_hi_q;
			end
			if (half_end || phase_end) begin
				half_cnt_q <= 32'h0000_0000;
				wave_q <= !wave_q;
			end else begin
				half_cnt_q <= half_cnt_q + 1'b1;
			end
		end
	end

	assign wave_o = wave_q;

endmodule

// File: dv/hfa_chk_sva.sv
`timescale 1ns/10ps
module hfa_chk (
	// Clock and reset
	input wire logic clock_i,
	input wire logic srst_i,
	// Host side
	input wire hfa_pkg::hfa_io_req_s io_req_i,
	input wire logic [7:0] io_rdata_o,
	input wire logic io_rvalid_o,
	input wire hfa_pkg::hfa_cfg_s cfg_i,
	input wire logic [3:0] bank_select_i,
	// Fan and tone
	input wire logic system_fan_drive_o,
	input wire logic [5:0] fan_dc_level_o,
	input wire logic fan_dc_mode_o,
	input wire logic alarm_tone_out_o,
	input wire logic alarm_tone_oe_o
);
	// Port hits; shadow of index and master enable
	wire [15:0] base = {cfg_i.high, cfg_i.low};
	wire at_idx = io_req_i.addr == base + hfa_pkg::INDEX_PORT_OFS;
	wire at_dat = io_req_i.addr == base + hfa_pkg::DATA_PORT_OFS;
	wire rd_hit = io_req_i.rd && (at_idx || at_dat);
	wire b0_wr = io_req_i.wr && at_dat && bank_select_i == 4'h0;
	logic [6:0] idx_q;
	logic mst_q;
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			idx_q <= 7'h00;
			mst_q <= 1'b0;
		end else begin
			if (io_req_i.wr && at_idx) idx_q <= io_req_i.wdata[6:0];
			if (b0_wr && idx_q == 7'h57) mst_q <= io_req_i.wdata[7];
		end
	end
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (srst_i);
	a_read_answer: assert property (rd_hit |=> io_rvalid_o)
		else $error("read not answered");
	a_no_stray: assert property (!rd_hit |=> !io_rvalid_o)
		else $error("answer without read");
	a_index_read: assert property (io_req_i.rd && at_idx
		|=> io_rdata_o == {1'b0, $past(idx_q)})
		else $error("index readback wrong");
	a_rdata_hold: assert property (!rd_hit |=> $stable(io_rdata_o))
		else $error("read data moved");
	a_dc_quiet: assert property (fan_dc_mode_o [*3]
		|-> !system_fan_drive_o)
		else $error("drive active in level mode");
	a_level_code: assert property (b0_wr && idx_q == 7'h01
		|-> ##2 fan_dc_level_o == $past(io_req_i.wdata[7:2], 2))
		else $error("level code wrong");
	a_open_drain: assert property (!alarm_tone_out_o)
		else $error("tone pin driven high");
	a_serial_free: assert property (cfg_i.pin_function[1] [*2]
		|-> !alarm_tone_oe_o)
		else $error("pin driven in serial mode");
	a_idle_low: assert property ((!mst_q && !cfg_i.pin_function[1]) [*3]
		|-> alarm_tone_oe_o)
		else $error("tone without master enable");
	c_read: cover property (rd_hit ##1 io_rvalid_o);
	c_pwm: cover property (!fan_dc_mode_o ##1 $rose(system_fan_drive_o));
	c_tone: cover property (mst_q && $fell(alarm_tone_oe_o));
endmodule

// File: dv/hfa_host_model.sv
`timescale 1ns/10ps
module hfa_host_model (
	// Clock
	input wire logic clock_i,
	// Byte I/O towards the block
	output hfa_pkg::hfa_io_req_s io_req_o,
	input wire logic [7:0] io_rdata_i,
	input wire logic io_rvalid_i
);
	initial io_req_o = '0;
	// One-cycle strobe; idle bus shows inverted values, never stale ones
	task automatic cyc(input logic w, input logic [15:0] a,
		input logic [7:0] d);
		io_req_o = '{addr: a, wr: w, rd: !w, wdata: d};
		@(posedge clock_i);
		#1;
		io_req_o = '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: ~d};
		// One idle edge, so two calls never share a time step
		@(posedge clock_i);
		#1;
	endtask
	// Read waits a bounded time, refused reads return ok low
	task automatic rd(input logic [15:0] a, output logic [7:0] d,
		output logic ok);
		io_req_o = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
		@(posedge clock_i);
		#1;
		io_req_o = '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: 8'hFF};
		ok = 1'b0;
		d = 8'h00;
		// The answer stands in the cycle after the strobe edge
		for (int n = 0; n < 3 && !ok; n++) begin
			ok = io_rvalid_i;
			d = io_rdata_i;
			@(posedge clock_i);
			#1;
		end
	endtask
endmodule

// File: dv/hwmon_fan_drive_and_alarm_tone_tb_top.sv
`timescale 1ns/10ps
module hwmon_fan_drive_and_alarm_tone_tb_top;
	// ----
	// Design, host and helpers
	// ----
	logic clock_i = 1'b0;
	logic srst_i = 1'b1;
	hfa_pkg::hfa_io_req_s io_req;
	hfa_pkg::hfa_cfg_s cfg = '{8'h02, 8'h90, 8'h00};
	logic [3:0] bank = 4'h0;
	logic [16:0] ev = '0;
	logic [7:0] rdata;
	logic rvalid, drive, dc_mode, tone, tone_oe;
	logic [5:0] dc_level;
	int n_errors = 0;
	int checks = 0;
	wire [15:0] base = {cfg.high, cfg.low};
	// Divider never zero; last case takes the slow source
	logic [7:0] fq [6] = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h04, 8'h81};
	logic [7:0] lv [6] = '{8'h00, 8'hFF, 8'h80, 8'h01, 8'h01, 8'h02};
	int lo [6] = '{0, 1995, 1000, 1, 12, 540};
	int hi [6] = '{0, 2000, 1130, 10, 22, 1125};
	always #5 clock_i = ~clock_i;
	hfa_top #(.TONE_LO_HALF(5), .TONE_HI_HALF(3), .TONE_PHASE_CYC(40)) dut_u (
		.clock_i(clock_i), .srst_i(srst_i), .io_req_i(io_req),
		.io_rdata_o(rdata), .io_rvalid_o(rvalid), .cfg_i(cfg),
		.bank_select_i(bank), .event_i(ev), .system_fan_drive_o(drive),
		.fan_dc_level_o(dc_level), .fan_dc_mode_o(dc_mode),
		.alarm_tone_out_o(tone), .alarm_tone_oe_o(tone_oe));
	hfa_host_model host_u (.clock_i(clock_i), .io_req_o(io_req),
		.io_rdata_i(rdata), .io_rvalid_i(rvalid));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Counted widths may drift a little with the uneven tick source
	task automatic rng(input int got, input int l, input int h);
		checks++;
		if (got < l || got > h) begin
			n_errors++;
			$display("BAD t=%0t got=%h exp=%h..%h", $time, got, l, h);
		end
	endtask
	task automatic rdp(input logic [15:0] a, input logic [7:0] exp);
		logic [7:0] d;
		logic ok;
		host_u.rd(a, d, ok);
		chk({7'h00, ok}, 8'h01);
		chk(d, exp);
	endtask
	task automatic wr(input logic [6:0] i, input logic [7:0] d);
		host_u.cyc(1'b1, base + 16'h0005, {1'b0, i});
		host_u.cyc(1'b1, base + 16'h0006, d);
	endtask
	task automatic rdx(input logic [6:0] i, input logic [7:0] exp);
		host_u.cyc(1'b1, base + 16'h0005, {1'b0, i});
		rdp(base + 16'h0006, exp);
	endtask
	// High cycles of the fan drive and changes of the tone pin
	task automatic cnt(input int n, output int h, output int t);
		logic last;
		h = 0;
		t = 0;
		last = tone_oe;
		// Look just after each edge, once the outputs have settled
		repeat (n) begin
			@(posedge clock_i);
			#1;
			// An unknown drive level swamps the count and fails it
			h += (drive === 1'b1) ? 1 : ((drive === 1'b0) ? 0 : n + 1);
			t += int'(tone_oe !== last);
			last = tone_oe;
		end
	endtask
	task automatic final_report();
		$display("checks=%0d n_errors=%0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// Watchdog: the tests need about 13000 cycles
	initial begin
		#400_000;
		n_errors++;
		final_report();
	end
	initial begin
		int h, t;
		logic [7:0] d;
		logic ok;
		repeat (20) @(posedge clock_i);
		#1;
		srst_i = 1'b0;
		@(posedge clock_i);
		#1;
		rdp(base + 16'h0005, 8'h00);
		rdx(7'h00, 8'h04);
		rdx(7'h01, 8'hFF);
		rdx(7'h04, 8'h01);
		chk({7'h00, dc_mode}, 8'h01);
		chk({2'b00, dc_level}, 8'h3F);
		chk({7'h00, tone}, 8'h00);
		$display("test reset done");
		host_u.cyc(1'b1, base + 16'h0005, 8'hFF);
		rdp(base + 16'h0005, 8'h7F);
		host_u.rd(base + 16'h0007, d, ok);
		chk({7'h00, ok}, 8'h00);
		cfg.high = 8'h0A;
		rdx(7'h01, 8'hFF);
		cfg.high = 8'h02;
		bank = 4'h4;
		rdx(7'h00, 8'h00);
		wr(7'h53, 8'hFF);
		rdx(7'h53, 8'h23);
		wr(7'h53, 8'h00);
		bank = 4'h0;
		wr(7'h04, 8'hFF);
		rdx(7'h04, 8'h3F);
		rdx(7'h10, 8'h00);
		$display("test ports done");
		for (int k = 0; k < 6; k++) begin
			wr(7'h04, 8'h01);
			wr(7'h00, fq[k]);
			wr(7'h01, lv[k]);
			wr(7'h04, 8'h00);
			cnt(2000, h, t);
			rng(h, lo[k], hi[k]);
		end
		wr(7'h04, 8'h01);
		cnt(10, h, t);
		cnt(100, h, t);
		rng(h, 0, 0);
		$display("test fan done");
		wr(7'h57, 8'h80);
		ev = 17'h1_FFFF;
		cnt(60, h, t);
		rng(t, 0, 0);
		chk({7'h00, tone_oe}, 8'h01);
		ev = '0;
		wr(7'h56, 8'hFF);
		wr(7'h57, 8'hFF);
		bank = 4'h4;
		wr(7'h53, 8'h03);
		bank = 4'h0;
		ev = 17'h0_0001;
		cnt(40, h, t);
		rng(t, 6, 9);
		cnt(40, h, t);
		rng(t, 11, 15);
		for (int i = 0; i < 17; i++) begin
			ev = 17'h0_0001 << i;
			cnt(12, h, t);
			rng(t, 1, 12);
			ev = '0;
			cnt(6, h, t);
		end
		cnt(20, h, t);
		rng(t, 0, 0);
		chk({7'h00, tone_oe}, 8'h01);
		ev = 17'h0_0001;
		wr(7'h57, 8'h7F);
		cnt(4, h, t);
		cnt(40, h, t);
		rng(t, 0, 0);
		ev = '0;
		wr(7'h57, 8'h80);
		bank = 4'h4;
		wr(7'h53, 8'h20);
		bank = 4'h0;
		cnt(12, h, t);
		rng(t, 1, 12);
		cfg.pin_function = 8'h02;
		cnt(4, h, t);
		cnt(20, h, t);
		rng(t, 0, 0);
		chk({7'h00, tone_oe}, 8'h00);
		$display("test tone done");
		final_report();
	end
endmodule
bind hfa_top hfa_chk chk_u (.clock_i(clock_i), .srst_i(srst_i),
	.io_req_i(io_req_i), .io_rdata_o(io_rdata_o), .io_rvalid_o(io_rvalid_o),
	.cfg_i(cfg_i), .bank_select_i(bank_select_i),
	.system_fan_drive_o(system_fan_drive_o), .fan_dc_level_o(fan_dc_level_o),
	.fan_dc_mode_o(fan_dc_mode_o), .alarm_tone_out_o(alarm_tone_out_o),
	.alarm_tone_oe_o(alarm_tone_oe_o));
